// ---- logic/exec_pkg.sv ----
`default_nettype none
package exec_pkg;
   // datapath shape
   localparam int DATA_W     = 8;
   localparam int PC_W       = 13;
   localparam int MEM_WORDS  = 32;
   localparam int MEM_AW     = 5;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W       = 3;
   localparam int OFS_W      = 8;

   // register byte offsets
   localparam logic [7:0] OFS_INSTR    = 8'h00;
   localparam logic [7:0] OFS_ACC      = 8'h04;
   localparam logic [7:0] OFS_PC       = 8'h08;
   localparam logic [7:0] OFS_STATUS   = 8'h0C;
   localparam logic [7:0] OFS_STACK    = 8'h10;
   localparam logic [7:0] OFS_MEM_BASE = 8'h80;

   // instruction word fields
   localparam int OP_LSB     = 24;
   localparam int OP_W       = 5;
   localparam int MADDR_LSB  = 16;
   localparam int IMM_LSB    = 0;
   localparam int TARGET_LSB = 0;

   // status register bit positions
   localparam int ST_CARRY  = 0;
   localparam int ST_HALF   = 1;
   localparam int ST_ZERO   = 2;
   localparam int ST_EXCESS = 3;
   localparam int ST_GIE    = 4;
   localparam int ST_BUSY   = 5;
   localparam int ST_SP_LSB = 8;

   // values after reset
   localparam logic [7:0]  ACC_RST   = 8'h00;
   localparam logic [12:0] PC_RST    = 13'h0000;
   localparam logic [31:0] INSTR_RST = 32'h0000_0000;
   localparam logic [2:0]  SP_RST    = 3'h0;

   // counts
   localparam logic [12:0] PC_STEP      = 13'h0001;
   localparam logic [12:0] PC_SKIP_STEP = 13'h0002;
   localparam logic [2:0]  SP_ONE       = 3'h1;

   typedef enum logic [4:0] {
      OP_IDLE           = 5'h00,
      OP_BRANCH         = 5'h01,
      OP_COPY_M2A       = 5'h02,
      OP_COPY_IMM       = 5'h03,
      OP_COPY_A2M       = 5'h04,
      OP_OR_MEM         = 5'h05,
      OP_OR_IMM         = 5'h06,
      OP_OR_INTO_RAM    = 5'h07,
      OP_SUB_EXIT       = 5'h08,
      OP_SUB_EXIT_IMM   = 5'h09,
      OP_INT_EXIT       = 5'h0A,
      OP_ROT_L          = 5'h0B,
      OP_ROT_L_ACC      = 5'h0C,
      OP_ROT_LC         = 5'h0D,
      OP_ROT_LC_ACC     = 5'h0E,
      OP_ROT_R          = 5'h0F,
      OP_ROT_R_ACC      = 5'h10,
      OP_ROT_RC         = 5'h11,
      OP_ROT_RC_ACC     = 5'h12,
      OP_SUB_BORROW     = 5'h13,
      OP_SUB_BORROW_RAM = 5'h14,
      OP_DEC_SKIP       = 5'h15,
      OP_DEC_SKIP_ACC   = 5'h16
   } op_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_DUMMY = 2'b10
   } exec_state_t;
endpackage
`default_nettype wire

// ---- logic/exec_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
module exec_alu
   import exec_pkg::*;
(
   // operation and operands
   input  wire exec_pkg::op_t op,
   input  wire logic [7:0]    acc,
   input  wire logic [7:0]    mem,
   input  wire logic [7:0]    imm,
   input  wire logic          carry_in,
   // result and flag candidates
   output logic [7:0]         result,
   output logic               carry_out,
   output logic               half_out,
   output logic               excess_out,
   output logic               zero_out
);
   logic [8:0] sum9;
   logic [4:0] lo5;

   always_comb begin
      // acc + ~mem + carry: carry set means no borrow
      sum9       = {1'b0, acc} + {1'b0, ~mem} + {8'h00, carry_in};
      lo5        = {1'b0, acc[3:0]} + {1'b0, ~mem[3:0]} + {4'h0, carry_in};
      result     = acc;
      carry_out  = carry_in;
      half_out   = lo5[4];
      excess_out = (acc[7] == ~mem[7]) && (sum9[7] != acc[7]);
      case (op)
         OP_COPY_M2A:                    result = mem;
         OP_COPY_IMM, OP_SUB_EXIT_IMM:   result = imm;
         OP_COPY_A2M:                    result = acc;
         OP_OR_MEM, OP_OR_INTO_RAM:      result = acc | mem;
         OP_OR_IMM:                      result = acc | imm;
         OP_ROT_L, OP_ROT_L_ACC:         result = {mem[6:0], mem[7]};
         OP_ROT_LC, OP_ROT_LC_ACC: begin
            result    = {mem[6:0], carry_in};
            carry_out = mem[7];
         end
         OP_ROT_R, OP_ROT_R_ACC:         result = {mem[0], mem[7:1]};
         OP_ROT_RC, OP_ROT_RC_ACC: begin
            result    = {carry_in, mem[7:1]};
            carry_out = mem[0];
         end
         OP_SUB_BORROW, OP_SUB_BORROW_RAM: begin
            result    = sum9[7:0];
            carry_out = sum9[8];
         end
         OP_DEC_SKIP, OP_DEC_SKIP_ACC:   result = mem - 8'h01;
         default:                        result = acc;
      endcase
      zero_out = (result == 8'h00);
   end
endmodule // exec_alu
`default_nettype wire

// ---- logic/exec_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module exec_unit
   import exec_pkg::*;
(
   // clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // core state
   output logic [7:0]       accumulator,
   output logic [12:0]      program_counter,
   output logic             global_interrupt_enable
);
   typedef struct packed {
      exec_state_t                     state;
      logic [7:0]                      acc;
      logic [12:0]                     pc;
      logic                            c;
      logic                            hc;
      logic                            z;
      logic                            ov;
      logic                            gie;
      logic [SP_W-1:0]                 sp;
      logic [STACK_DEPTH-1:0][12:0]    stack;
      logic [MEM_WORDS-1:0][7:0]       mem;
      logic [31:0]                     instr;
      logic                            wr_pend;
      logic [7:0]                      wr_addr;
      logic [31:0]                     hrdata;
      logic                            hreadyout;
      logic                            hresp;
   } unit_t;

   unit_t s_r;
   unit_t s_nxt;

   op_t              alu_op;
   logic [MEM_AW-1:0] maddr;
   logic [7:0]       alu_mem;
   logic [7:0]       imm;
   logic [7:0]       alu_res;
   logic             alu_c;
   logic             alu_hc;
   logic             alu_ov;
   logic             alu_z;
   logic [SP_W-1:0]  sp_dec;
   logic [12:0]      stack_top;
   logic             exec_go;
   logic [3:0]       flag_vec;

   function automatic logic is_mem_addr(input logic [7:0] a);
      is_mem_addr = (a >= OFS_MEM_BASE) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic writes_acc(input op_t op);
      case (op)
         OP_COPY_M2A, OP_COPY_IMM, OP_OR_MEM, OP_OR_IMM, OP_SUB_EXIT_IMM,
         OP_ROT_L_ACC, OP_ROT_LC_ACC, OP_ROT_R_ACC, OP_ROT_RC_ACC,
         OP_SUB_BORROW, OP_DEC_SKIP_ACC: writes_acc = 1'b1;
         default:                        writes_acc = 1'b0;
      endcase
   endfunction

   function automatic logic writes_mem(input op_t op);
      case (op)
         OP_COPY_A2M, OP_OR_INTO_RAM, OP_ROT_L, OP_ROT_LC, OP_ROT_R,
         OP_ROT_RC, OP_SUB_BORROW_RAM, OP_DEC_SKIP: writes_mem = 1'b1;
         default:                                  writes_mem = 1'b0;
      endcase
   endfunction

   function automatic logic sets_zero(input op_t op);
      sets_zero = (op == OP_OR_MEM) || (op == OP_OR_IMM) || (op == OP_OR_INTO_RAM) ||
                  (op == OP_SUB_BORROW) || (op == OP_SUB_BORROW_RAM);
   endfunction

   // the instruction executes in the write data phase, straight off hwdata
   assign alu_op    = op_t'(hwdata[OP_LSB +: OP_W]);
   assign maddr     = hwdata[MADDR_LSB +: MEM_AW];
   assign imm       = hwdata[IMM_LSB +: DATA_W];
   assign alu_mem   = s_r.mem[maddr];
   assign sp_dec    = s_r.sp - SP_ONE;
   assign stack_top = s_r.stack[sp_dec];
   assign exec_go   = ce && s_r.wr_pend && (s_r.state == ST_IDLE) && (s_r.wr_addr == OFS_INSTR);
   assign flag_vec  = {s_r.c, s_r.hc, s_r.z, s_r.ov};

   exec_alu alu (
      .op         (alu_op),
      .acc        (s_r.acc),
      .mem        (alu_mem),
      .imm        (imm),
      .carry_in   (s_r.c),
      .result     (alu_res),
      .carry_out  (alu_c),
      .half_out   (alu_hc),
      .excess_out (alu_ov),
      .zero_out   (alu_z)
   );

   always_comb begin
      s_nxt = s_r;
      if (ce) begin
         s_nxt.wr_pend = 1'b0;
         if (s_r.state == ST_DUMMY) begin
            s_nxt.state = ST_IDLE;
         end
         // address phase: writes wait for their data phase, reads answer now
         if (hsel && hready && htrans[1]) begin
            if (hwrite) begin
               s_nxt.wr_pend = 1'b1;
               s_nxt.wr_addr = haddr[7:0];
            end else if (haddr[7:0] == OFS_INSTR) begin
               s_nxt.hrdata = s_r.instr;
            end else if (haddr[7:0] == OFS_ACC) begin
               s_nxt.hrdata = {24'h000000, s_r.acc};
            end else if (haddr[7:0] == OFS_PC) begin
               s_nxt.hrdata = {19'h00000, s_r.pc};
            end else if (haddr[7:0] == OFS_STATUS) begin
               s_nxt.hrdata = {21'h000000, s_r.sp, 2'b00, (s_r.state == ST_DUMMY), s_r.gie,
                               s_r.ov, s_r.z, s_r.hc, s_r.c};
            end else if (haddr[7:0] == OFS_STACK) begin
               s_nxt.hrdata = {19'h00000, stack_top};
            end else if (is_mem_addr(haddr[7:0])) begin
               s_nxt.hrdata = {24'h000000, s_r.mem[haddr[6:2]]};
            end else begin
               s_nxt.hrdata = 32'h0000_0000;
            end
         end
         // data phase: writes during the dummy cycle are dropped
         if (s_r.wr_pend && (s_r.state == ST_IDLE)) begin
            if (s_r.wr_addr == OFS_INSTR) begin
               s_nxt.instr = hwdata;
               s_nxt.pc    = s_r.pc + PC_STEP;
               if (writes_acc(alu_op)) begin
                  s_nxt.acc = alu_res;
               end
               if (writes_mem(alu_op)) begin
                  s_nxt.mem[maddr] = alu_res;
               end
               if (sets_zero(alu_op)) begin
                  s_nxt.z = alu_z;
               end
               case (alu_op)
                  OP_BRANCH: begin
                     s_nxt.pc = hwdata[TARGET_LSB +: PC_W];
                  end
                  OP_SUB_EXIT, OP_SUB_EXIT_IMM, OP_INT_EXIT: begin
                     // reload needs a refill cycle, so returns are two cycles
                     s_nxt.pc    = stack_top;
                     s_nxt.sp    = sp_dec;
                     s_nxt.state = ST_DUMMY;
                     if (alu_op == OP_INT_EXIT) begin
                        s_nxt.gie = 1'b1;
                     end
                  end
                  OP_ROT_LC, OP_ROT_LC_ACC, OP_ROT_RC, OP_ROT_RC_ACC: begin
                     s_nxt.c = alu_c;
                  end
                  OP_SUB_BORROW, OP_SUB_BORROW_RAM: begin
                     s_nxt.c  = alu_c;
                     s_nxt.hc = alu_hc;
                     s_nxt.ov = alu_ov;
                  end
                  OP_DEC_SKIP, OP_DEC_SKIP_ACC: begin
                     if (alu_z) begin
                        s_nxt.pc    = s_r.pc + PC_SKIP_STEP;
                        s_nxt.state = ST_DUMMY;
                     end
                  end
                  default: begin
                  end
               endcase
            end else if (s_r.wr_addr == OFS_ACC) begin
               s_nxt.acc = hwdata[7:0];
            end else if (s_r.wr_addr == OFS_PC) begin
               s_nxt.pc = hwdata[12:0];
            end else if (s_r.wr_addr == OFS_STATUS) begin
               s_nxt.c   = hwdata[ST_CARRY];
               s_nxt.hc  = hwdata[ST_HALF];
               s_nxt.z   = hwdata[ST_ZERO];
               s_nxt.ov  = hwdata[ST_EXCESS];
               s_nxt.gie = hwdata[ST_GIE];
            end else if (s_r.wr_addr == OFS_STACK) begin
               // push wraps silently; the stack is circular with no overflow flag
               s_nxt.stack[s_r.sp] = hwdata[12:0];
               s_nxt.sp            = s_r.sp + SP_ONE;
            end else if (is_mem_addr(s_r.wr_addr)) begin
               s_nxt.mem[s_r.wr_addr[6:2]] = hwdata[7:0];
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r           <= '0;
         s_r.state     <= ST_IDLE;
         s_r.acc       <= ACC_RST;
         s_r.pc        <= PC_RST;
         s_r.sp        <= SP_RST;
         s_r.instr     <= INSTR_RST;
         s_r.hreadyout <= 1'b1;
         s_r.hresp     <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hrdata                  = s_r.hrdata;
   assign hreadyout               = s_r.hreadyout;
   assign hresp                   = s_r.hresp;
   assign accumulator             = s_r.acc;
   assign program_counter         = s_r.pc;
   assign global_interrupt_enable = s_r.gie;

   a_branch_target: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_BRANCH |=> s_r.pc == $past(hwdata[12:0]) && flag_vec == $past(flag_vec))
      else $error("branch target or flags wrong");
   a_copy_mem_acc: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_COPY_M2A |=> s_r.acc == $past(alu_mem) && flag_vec == $past(flag_vec))
      else $error("memory to accumulator copy wrong");
   a_copy_imm_acc: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_COPY_IMM |=> s_r.acc == $past(imm) && flag_vec == $past(flag_vec))
      else $error("immediate load wrong");
   a_copy_acc_mem: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_COPY_A2M |=> s_r.mem[$past(maddr)] == $past(s_r.acc))
      else $error("accumulator to memory copy wrong");
   a_idle_step: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_IDLE |=> s_r.pc == 13'($past(s_r.pc) + PC_STEP)
      && s_r.acc == $past(s_r.acc) && flag_vec == $past(flag_vec))
      else $error("idle instruction changed state");
   a_or_zero_acc: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_OR_MEM |=> s_r.acc == ($past(s_r.acc) | $past(alu_mem))
      && s_r.z == (s_r.acc == 8'h00) && s_r.c == $past(s_r.c))
      else $error("or into accumulator wrong");
   a_or_into_mem: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_OR_INTO_RAM |=> s_r.mem[$past(maddr)] == ($past(s_r.acc) | $past(alu_mem))
      && s_r.z == (s_r.mem[$past(maddr)] == 8'h00))
      else $error("or into memory wrong");
   a_exit_two_cycle: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_SUB_EXIT && ce |=> s_r.pc == $past(stack_top) && s_r.state == ST_DUMMY
      ##1 (s_r.state == ST_IDLE || !$past(ce)))
      else $error("subroutine exit not two cycles");
   a_exit_with_imm: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_SUB_EXIT_IMM |=> s_r.acc == $past(imm) && s_r.pc == $past(stack_top))
      else $error("return with constant wrong");
   a_int_exit_gie: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_INT_EXIT |=> global_interrupt_enable && flag_vec == $past(flag_vec))
      else $error("interrupt exit did not enable");
   a_rotate_carry: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_ROT_RC_ACC |=> s_r.acc == {$past(s_r.c), $past(alu_mem[7:1])}
      && s_r.c == $past(alu_mem[0]))
      else $error("rotate right through carry wrong");
   a_sub_borrow: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_SUB_BORROW |=> s_r.acc == 8'($past(s_r.acc) + ~$past(alu_mem) + {7'h00, $past(s_r.c)}))
      else $error("subtract with borrow result wrong");
   a_dec_skip_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_DEC_SKIP && alu_mem == 8'h01 |=> s_r.pc == 13'($past(s_r.pc) + PC_SKIP_STEP)
      && s_r.state == ST_DUMMY && s_r.mem[$past(maddr)] == 8'h00)
      else $error("decrement skip on zero wrong");
   a_or_imm_acc: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_OR_IMM |=> s_r.acc == ($past(s_r.acc) | $past(imm))
      && s_r.z == (s_r.acc == 8'h00) && s_r.ov == $past(s_r.ov))
      else $error("or with immediate wrong");
   a_rotate_left: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_ROT_L |=> s_r.mem[$past(maddr)] == {$past(alu_mem[6:0]), $past(alu_mem[7])}
      && s_r.acc == $past(s_r.acc) && flag_vec == $past(flag_vec))
      else $error("rotate left into memory wrong");
   a_rotate_left_acc: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_ROT_L_ACC |=> s_r.acc == {$past(alu_mem[6:0]), $past(alu_mem[7])}
      && s_r.mem[$past(maddr)] == $past(alu_mem) && flag_vec == $past(flag_vec))
      else $error("rotate left to accumulator wrong");
   a_rotl_carry_mem: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_ROT_LC |=> s_r.mem[$past(maddr)] == {$past(alu_mem[6:0]), $past(s_r.c)}
      && s_r.c == $past(alu_mem[7]) && s_r.z == $past(s_r.z))
      else $error("rotate left through carry wrong");
   a_rotl_carry_acc: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_ROT_LC_ACC |=> s_r.acc == {$past(alu_mem[6:0]), $past(s_r.c)}
      && s_r.c == $past(alu_mem[7]) && s_r.mem[$past(maddr)] == $past(alu_mem))
      else $error("rotate left through carry to accumulator wrong");
   a_rotate_right: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_ROT_R |=> s_r.mem[$past(maddr)] == {$past(alu_mem[0]), $past(alu_mem[7:1])}
      && s_r.acc == $past(s_r.acc) && flag_vec == $past(flag_vec))
      else $error("rotate right into memory wrong");
   a_rotate_right_acc: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_ROT_R_ACC |=> s_r.acc == {$past(alu_mem[0]), $past(alu_mem[7:1])}
      && s_r.mem[$past(maddr)] == $past(alu_mem) && flag_vec == $past(flag_vec))
      else $error("rotate right to accumulator wrong");
   a_sub_borrow_ram: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_SUB_BORROW_RAM |=> s_r.acc == $past(s_r.acc)
      && s_r.mem[$past(maddr)] == 8'($past(s_r.acc) + ~$past(alu_mem) + {7'h00, $past(s_r.c)}))
      else $error("subtract with borrow into memory wrong");
   a_sub_carry_out: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_SUB_BORROW |=> s_r.c == ({1'b0, $past(s_r.acc)} + {1'b0, ~$past(alu_mem)}
      + {8'h00, $past(s_r.c)} > 9'h0FF) && s_r.z == (s_r.acc == 8'h00))
      else $error("subtract with borrow carry or zero wrong");
   a_sub_zero_ram: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_SUB_BORROW_RAM |=> s_r.z == (s_r.mem[$past(maddr)] == 8'h00))
      else $error("zero flag after subtract into memory wrong");
   a_dec_skip_other: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_DEC_SKIP && alu_mem != 8'h01 |=> s_r.pc == 13'($past(s_r.pc) + PC_STEP)
      && s_r.state == ST_IDLE && s_r.mem[$past(maddr)] == 8'($past(alu_mem) - 8'h01) && flag_vec == $past(flag_vec))
      else $error("decrement skip on nonzero wrong");
   a_dec_skip_acc: assert property (@(posedge hclk) disable iff (!hresetn)
      exec_go && alu_op == OP_DEC_SKIP_ACC |=> s_r.acc == 8'($past(alu_mem) - 8'h01)
      && s_r.mem[$past(maddr)] == $past(alu_mem) && s_r.state == (($past(alu_mem) == 8'h01) ? ST_DUMMY : ST_IDLE))
      else $error("decrement skip to accumulator wrong");
   a_enable_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
      !ce |=> s_r == $past(s_r))
      else $error("state moved while enable low");
endmodule // exec_unit
`default_nettype wire

// ---- testbench/mcu_instruction_execute_subset_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_execute_subset_bench;
   import exec_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        ce = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   wire logic   hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [7:0]  accumulator;
   logic [12:0] program_counter;
   logic        global_interrupt_enable;
   // expected core state
   logic [7:0]  e_acc, e_mem [32];
   logic [12:0] e_pc, e_stk [8];
   logic [2:0]  e_sp;
   logic        e_c, e_h, e_z, e_v, e_gie;
   int          n_compared = 0;
   int          n_mismatch = 0;

   // single slave, so its ready is the bus ready
   assign hready = hreadyout;

   always #12.5 hclk = ~hclk;

   exec_unit dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .accumulator(accumulator), .program_counter(program_counter),
      .global_interrupt_enable(global_interrupt_enable));

   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // bounded wait, a stuck ready must not hang the run
   task automatic wait_rdy();
      int k;
      for (k = 0; k < 16; k++) begin
         @(posedge hclk);
         if (hready === 1'b1) break;
      end
      if (k == 16) begin
         n_mismatch++;
         $display("ERROR %0t bus ready never came", $time);
         tally_and_finish();
      end
   endtask

   task automatic addr_ph(input logic [31:0] a, input logic w);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      addr_ph(a, 1'b1);
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      addr_ph(a, 1'b0);
      wait_rdy();
      d = hrdata;
      chk({31'h0, hresp}, 32'h0, "okay response");
   endtask

   function automatic logic [31:0] mem_a(input logic [4:0] ma);
      return {24'h0, OFS_MEM_BASE} + {25'h0, ma, 2'b00};
   endfunction

   function automatic void predict(input logic [4:0] op, input logic [4:0] ma, input logic [12:0] t);
      logic [7:0] m;
      logic [7:0] r;
      logic [8:0] s;
      m = e_mem[ma];
      r = 8'h00;
      e_pc = e_pc + 13'h0001;
      case (op)
         5'h01: e_pc = t;
         5'h02: e_acc = m;
         5'h03: e_acc = t[7:0];
         5'h04: e_mem[ma] = e_acc;
         5'h05, 5'h06, 5'h07: begin
            r = e_acc | ((op == 5'h06) ? t[7:0] : m);
            e_z = (r == 8'h00);
            if (op == 5'h07) e_mem[ma] = r;
            else e_acc = r;
         end
         5'h08, 5'h09, 5'h0A: begin
            e_sp = e_sp - 3'h1;
            e_pc = e_stk[e_sp];
            if (op == 5'h09) e_acc = t[7:0];
            if (op == 5'h0A) e_gie = 1'b1;
         end
         5'h0B, 5'h0C: r = {m[6:0], m[7]};
         5'h0D, 5'h0E: begin
            r = {m[6:0], e_c};
            e_c = m[7];
         end
         5'h0F, 5'h10: r = {m[0], m[7:1]};
         5'h11, 5'h12: begin
            r = {e_c, m[7:1]};
            e_c = m[0];
         end
         5'h13, 5'h14: begin
            s = {1'b0, e_acc} + {1'b0, ~m} + {8'h00, e_c};
            r = s[7:0];
            e_h = ({1'b0, e_acc[3:0]} + {1'b0, ~m[3:0]} + {4'h0, e_c}) > 5'h0F;
            e_v = (e_acc[7] == ~m[7]) && (r[7] != e_acc[7]);
            e_c = s[8];
            e_z = (r == 8'h00);
         end
         5'h15, 5'h16: begin
            r = m - 8'h01;
            if (r == 8'h00) e_pc = e_pc + 13'h0001;
         end
         default: ;
      endcase
      if (op >= 5'h0B && op <= 5'h16) begin
         if (op inside {5'h0C, 5'h0E, 5'h10, 5'h12, 5'h13, 5'h16}) e_acc = r;
         else e_mem[ma] = r;
      end
   endfunction

   task automatic load(input logic [4:0] ma, input logic [7:0] m, input logic [7:0] a, input logic [4:0] st);
      wr(mem_a(ma), {24'h0, m});
      wr({24'h0, OFS_ACC}, {24'h0, a});
      wr({24'h0, OFS_STATUS}, {27'h0, st});
      e_mem[ma] = m;
      e_acc = a;
      {e_gie, e_v, e_z, e_h, e_c} = st;
   endtask

   // the idle edge lets the dummy cycle of two-cycle ops pass before reading
   task automatic run_op(input logic [4:0] op, input logic [4:0] ma, input logic [12:0] t);
      logic [31:0] d;
      wr({24'h0, OFS_INSTR}, {3'h0, op, 3'h0, ma, 3'h0, t});
      predict(op, ma, t);
      @(posedge hclk);
      chk({24'h0, accumulator}, {24'h0, e_acc}, "acc");
      chk({19'h0, program_counter}, {19'h0, e_pc}, "pc");
      chk({31'h0, global_interrupt_enable}, {31'h0, e_gie}, "gie");
      rd({24'h0, OFS_STATUS}, d);
      chk(d & 32'h0000_073F, {21'h0, e_sp, 3'h0, e_gie, e_v, e_z, e_h, e_c}, "status");
      rd(mem_a(ma), d);
      chk(d & 32'h0000_00FF, {24'h0, e_mem[ma]}, "mem");
   endtask

   initial begin
      logic [31:0] d;
      logic [12:0] v;
      logic [7:0]  ofs [7];
      void'($urandom(27017));
      ofs = '{OFS_INSTR, OFS_ACC, OFS_PC, OFS_STATUS, OFS_STACK, 8'h20, 8'h80};
      for (int i = 0; i < 32; i++) e_mem[i] = 8'h00;
      for (int i = 0; i < 8; i++) e_stk[i] = 13'h0000;
      {e_acc, e_pc, e_sp, e_c, e_h, e_z, e_v, e_gie} = '0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ofs[i]) begin
         rd({24'h0, ofs[i]}, d);
         chk(d, 32'h0, "reset value");
      end
      // unmapped place: write ignored, read zero
      wr(32'h0000_0040, 32'hFFFF_FFFF);
      rd(32'h0000_0040, d);
      chk(d, 32'h0, "unmapped");
      for (int i = 0; i < 5; i++) begin
         v = 13'($urandom);
         wr({24'h0, OFS_STACK}, {19'h0, v});
         e_stk[e_sp] = v;
         e_sp = e_sp + 3'h1;
      end
      v = 13'($urandom);
      wr({24'h0, OFS_PC}, {19'h0, v});
      e_pc = v;
      // enable low: bus writes are lost and nothing moves
      ce <= 1'b0;
      wr({24'h0, OFS_ACC}, ~{24'h0, e_acc});
      wr({24'h0, OFS_PC}, 32'h0000_1FFF ^ {19'h0, e_pc});
      ce <= 1'b1;
      rd({24'h0, OFS_ACC}, d);
      chk(d, {24'h0, e_acc}, "frozen acc");
      chk({19'h0, program_counter}, {19'h0, e_pc}, "frozen pc");
      // every code once, including unused ones
      for (int op = 0; op < 32; op++) begin
         load(5'(op), 8'($urandom), 8'($urandom), 5'($urandom));
         run_op(5'(op), 5'(op), 13'($urandom));
      end
      // skip boundary: result zero, and wrap from zero
      foreach (ofs[i]) begin
         load(5'h03, (i < 2) ? 8'h01 : 8'h00, 8'h5A, 5'h00);
         run_op((i % 2) ? 5'h16 : 5'h15, 5'h03, 13'h0000);
      end
      // subtract edges: zero result, signed overflow, borrow in
      load(5'h07, 8'h00, 8'h00, 5'h01);
      run_op(5'h13, 5'h07, 13'h0000);
      load(5'h07, 8'h01, 8'h80, 5'h01);
      run_op(5'h14, 5'h07, 13'h0000);
      load(5'h07, 8'h0F, 8'h10, 5'h00);
      run_op(5'h13, 5'h07, 13'h0000);
      for (int i = 0; i < 400; i++) begin
         if ($urandom % 3 == 0) load(5'($urandom), 8'($urandom), 8'($urandom), 5'($urandom));
         run_op(5'($urandom % 24), 5'($urandom), 13'($urandom));
      end
      tally_and_finish();
   end
endmodule // mcu_instruction_execute_subset_bench
`default_nettype wire
